// *** core/sdc_apb_dec.sv ***
// sdc_apb_dec: apb address decode and answer for the collector registers
// assumes a zero-wait slave: every access completes in its first access cycle
`timescale 1ns/100ps
module sdc_apb_dec (
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // decode results
  output logic [4:0] sel,
  output logic wr,
  output logic rd,
  output logic pready,
  output logic pslverr
);
  logic hit;
  always_comb begin
    sel = 5'h00;
    unique case (paddr)
      sdc_pkg::OFS_CTRL: sel[0] = 1'b1;
      sdc_pkg::OFS_CHK: sel[1] = 1'b1;
      sdc_pkg::OFS_RAW: sel[2] = 1'b1;
      sdc_pkg::OFS_STAT: sel[3] = 1'b1;
      sdc_pkg::OFS_MASK: sel[4] = 1'b1;
      default: sel = 5'h00;
    endcase
    hit = |sel;
    // no wait states, so the access phase is always the last
    pready = 1'b1;
    pslverr = psel & penable & ~hit;
    wr = psel & penable & pwrite & hit;
    // reads are fetched in the setup cycle so the access finds them in a flip-flop
    rd = psel & ~penable & ~pwrite & hit;
  end
endmodule : sdc_apb_dec

// *** core/sdc_clamp.sv ***
// sdc_clamp: priority choice of the analog clamp direction
// assumes flags are the sticky status bits of the collector
`timescale 1ns/100ps
module sdc_clamp (
  // flags
  input wire logic [7:0] flags,
  // clamp decision
  output logic active,
  output logic high
);
  always_comb begin
    active = 1'b1;
    high = 1'b0;
    // bridge, converter and memory faults pull low; compute pulls high
    if (flags[sdc_pkg::ST_SENSOR]) begin
      high = 1'b0;
    end else if (flags[sdc_pkg::ST_ADC]) begin
      high = 1'b0;
    end else if (flags[sdc_pkg::ST_CRC_MEM]) begin
      high = 1'b0;
    end else if (flags[sdc_pkg::ST_CALC]) begin
      high = 1'b1;
    end else if (flags[sdc_pkg::ST_TLOW]) begin
      high = 1'b0;
    end else if (flags[sdc_pkg::ST_THIGH]) begin
      high = 1'b1;
    end else begin
      active = 1'b0;
    end
  end
endmodule : sdc_clamp

// *** core/sdc_collector.sv ***
// sdc_collector: connection check sequencing, check word latch, error flags,
// buffered data marking and analog clamping, with an apb register file
// assumes the sequencer and front end share CLK; their strobes are one-cycle pulses
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module sdc_collector (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // conversion sequencer
  input wire logic CONV_START,
  input wire logic [1:0] CONV_KIND,
  input wire logic CONV_END,
  output logic CHK_RUN,
  output logic CONV_GO,
  // front end check result
  input wire logic CHK_DONE,
  input wire logic [15:0] CHK_VEC,
  // error sources
  input wire logic ADC_OVF,
  input wire logic ADC_UDF,
  input wire logic CALC_OVF,
  input wire logic CALC_UDF,
  input wire logic THR_HIGH,
  input wire logic THR_LOW,
  input wire logic BUF_ERR,
  input wire logic CRC_COM_ERR,
  input wire logic CRC_MEM_ERR,
  // buffered data path
  input wire logic DATA_VALID,
  input wire logic [23:0] DATA_IN,
  output logic BUF_VALID,
  output logic [23:0] BUF_DATA,
  // analog path
  input wire logic [13:0] DAC_IN,
  output logic [13:0] DAC_OUT,
  // interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // types and state

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_CONV = 2'b11
  } sdc_phase_e;

  typedef struct packed {
    sdc_phase_e phase;
    sdc_pkg::sdc_kind_e kind;
    logic [1:0] ctrl;
    logic [15:0] raw;
    logic raw_valid;
    logic [15:0] chk;
    logic [7:0] stat;
    logic [7:0] mask;
    logic go;
    logic adc_hit;
    logic calc_hit;
    logic buf_valid;
    logic [23:0] buf_data;
    logic [13:0] dac;
    logic [31:0] rdata;
  } sdc_state_s;

  sdc_state_s q;
  sdc_state_s next_q;

  logic [4:0] sel;
  logic wr;
  logic rd;
  logic clamp_active;
  logic clamp_high;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // mask selecting the check word group that belongs to a conversion kind
  function automatic logic [15:0] group_mask(input sdc_pkg::sdc_kind_e k);
    logic [15:0] m;
    m = 16'h0000;
    unique case (k)
      sdc_pkg::KIND_T2: m[sdc_pkg::G_T2_HI:sdc_pkg::G_T2_LO] = '1;
      sdc_pkg::KIND_T1: m[sdc_pkg::G_T1_HI:sdc_pkg::G_T1_LO] = '1;
      default: m[sdc_pkg::G_P_HI:sdc_pkg::G_P_LO] = '1;
    endcase
    return m;
  endfunction : group_mask

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  sdc_apb_dec u_dec (
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .sel(sel),
    .wr(wr),
    .rd(rd),
    .pready(PREADY),
    .pslverr(PSLVERR)
  );

  sdc_clamp u_clamp (
    .flags(q.stat),
    .active(clamp_active),
    .high(clamp_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] gm;
    logic [15:0] fresh;
    logic [7:0] ev;
    logic [7:0] w1c;
    logic retain;
    gm = group_mask(q.kind);
    fresh = q.raw & gm;
    ev = 8'h00;
    w1c = 8'h00;
    retain = q.ctrl[sdc_pkg::CTRL_RETAIN];
    next_q = q;
    next_q.go = 1'b0;
    next_q.buf_valid = 1'b0;

    // conversion sequencing: the check always precedes the conversion proper
    unique case (q.phase)
      ST_IDLE: begin
        if (CONV_START) begin
          next_q.phase = ST_CHECK;
          next_q.kind = sdc_pkg::sdc_kind_e'(CONV_KIND);
          next_q.raw_valid = 1'b0;
          next_q.adc_hit = 1'b0;
          next_q.calc_hit = 1'b0;
        end
      end
      ST_CHECK: begin
        if (CHK_DONE) begin
          next_q.raw = CHK_VEC;
          next_q.raw_valid = 1'b1;
          next_q.phase = ST_CONV;
          next_q.go = 1'b1;
        end
      end
      ST_CONV: begin
        if (CONV_END) begin
          next_q.phase = ST_IDLE;
          if (retain) begin
            // overwrite lets a recovered bridge read clean again
            next_q.chk = (q.chk & ~gm) | fresh;
          end else begin
            next_q.chk = q.chk | fresh;
          end
          ev[sdc_pkg::ST_SENSOR] = |fresh;
        end
      end
      default: next_q.phase = ST_IDLE;
    endcase

    // per-conversion converter and compute faults, used to mark data
    if (ADC_OVF | ADC_UDF) begin
      next_q.adc_hit = 1'b1;
    end
    if (CALC_OVF | CALC_UDF) begin
      next_q.calc_hit = 1'b1;
    end

    // event sources
    ev[sdc_pkg::ST_ADC] = ADC_OVF | ADC_UDF;
    ev[sdc_pkg::ST_CALC] = CALC_OVF | CALC_UDF;
    ev[sdc_pkg::ST_THIGH] = THR_HIGH;
    ev[sdc_pkg::ST_TLOW] = THR_LOW;
    ev[sdc_pkg::ST_BUF] = BUF_ERR;
    ev[sdc_pkg::ST_CRC_COM] = CRC_COM_ERR;
    ev[sdc_pkg::ST_CRC_MEM] = CRC_MEM_ERR;

    // register writes
    if (wr && sel[0]) begin
      next_q.ctrl = PWDATA[1:0];
    end
    if (wr && sel[4]) begin
      next_q.mask = PWDATA[7:0];
    end
    if (wr && sel[3]) begin
      w1c = PWDATA[7:0];
    end
    // a new event wins over a clear in the same cycle
    next_q.stat = (q.stat & ~w1c) | ev;

    // register reads, fetched in the setup cycle; all diagnostic bits visible
    next_q.rdata = 32'h00000000;
    if (rd) begin
      unique case (1'b1)
        sel[0]: next_q.rdata = {30'h00000000, q.ctrl};
        sel[1]: next_q.rdata = {16'h0000, q.chk};
        sel[2]: next_q.rdata = {15'h0000, q.raw_valid, q.raw};
        sel[3]: next_q.rdata = {24'h000000, q.stat};
        sel[4]: next_q.rdata = {24'h000000, q.mask};
        default: next_q.rdata = 32'h00000000;
      endcase
    end

    // buffered data: bridge fault first, then converter, then compute
    if (DATA_VALID) begin
      next_q.buf_valid = 1'b1;
      if (q.raw_valid && (|fresh)) begin
        next_q.buf_data = sdc_pkg::CODE_SENSOR;
      end else if (q.adc_hit) begin
        next_q.buf_data = sdc_pkg::CODE_ADC;
      end else if (q.calc_hit) begin
        next_q.buf_data = sdc_pkg::CODE_CALC;
      end else if (DATA_IN > sdc_pkg::CODE_MAX_DATA) begin
        // real data is kept out of the marker range
        next_q.buf_data = sdc_pkg::CODE_MAX_DATA;
      end else begin
        next_q.buf_data = DATA_IN;
      end
    end

    // analog output, clamped only with the analog fault enable
    if (q.ctrl[sdc_pkg::CTRL_ANA_EN] && clamp_active) begin
      next_q.dac = clamp_high ? sdc_pkg::DAC_FULL : sdc_pkg::DAC_ZERO;
    end else begin
      next_q.dac = DAC_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK) begin
    if (SRST) begin
      q.phase <= ST_IDLE;
      q.kind <= sdc_pkg::KIND_P;
      q.ctrl <= sdc_pkg::CTRL_RST;
      q.raw <= sdc_pkg::CHK_RST;
      q.raw_valid <= 1'b0;
      q.chk <= sdc_pkg::CHK_RST;
      q.stat <= sdc_pkg::STAT_RST;
      q.mask <= sdc_pkg::MASK_RST;
      q.go <= 1'b0;
      q.adc_hit <= 1'b0;
      q.calc_hit <= 1'b0;
      q.buf_valid <= 1'b0;
      q.buf_data <= 24'h000000;
      q.dac <= sdc_pkg::DAC_ZERO;
      q.rdata <= 32'h00000000;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // read data is taken in the setup cycle and stands registered in the access
  // cycle; the price of zero wait is that a read sees the registers one cycle old
  assign PRDATA = q.rdata;

  assign CHK_RUN = (q.phase == ST_CHECK);
  assign CONV_GO = q.go;
  assign BUF_VALID = q.buf_valid;
  assign BUF_DATA = q.buf_data;
  assign DAC_OUT = q.dac;
  assign IRQ = |(q.stat & q.mask);

endmodule : sdc_collector

// *** core/sdc_pkg.sv ***
// sdc_pkg: shared constants of the sensor diagnostic collector
// assumes APB with 32-bit data, one register per aligned word
package sdc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHK = 8'h04;
  localparam logic [7:0] OFS_RAW = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  // control fields
  localparam int CTRL_RETAIN = 0;
  localparam int CTRL_ANA_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // status / mask fields
  localparam int ST_SENSOR = 0;
  localparam int ST_ADC = 1;
  localparam int ST_CALC = 2;
  localparam int ST_THIGH = 3;
  localparam int ST_TLOW = 4;
  localparam int ST_BUF = 5;
  localparam int ST_CRC_COM = 6;
  localparam int ST_CRC_MEM = 7;
  localparam int ST_W = 8;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // check word groups
  localparam int G_T2_HI = 15;
  localparam int G_T2_LO = 13;
  localparam int G_T1_HI = 12;
  localparam int G_T1_LO = 10;
  localparam int G_P_HI = 9;
  localparam int G_P_LO = 0;
  localparam logic [15:0] CHK_RST = 16'h0000;
  // conversion kinds
  typedef enum logic [1:0] {KIND_P = 2'h0, KIND_T1 = 2'h1, KIND_T2 = 2'h2} sdc_kind_e;
  // buffered data codes: the eight highest values are diagnostic markers
  localparam logic [23:0] CODE_MAX_DATA = 24'hfffff7;
  localparam logic [23:0] CODE_SENSOR = 24'hfffff9;
  localparam logic [23:0] CODE_ADC = 24'hfffffa;
  localparam logic [23:0] CODE_CALC = 24'hfffffb;
  // analog clamp codes
  localparam logic [13:0] DAC_FULL = 14'h3fff;
  localparam logic [13:0] DAC_ZERO = 14'h0000;
endpackage : sdc_pkg

// *** tb/sdc_props_properties.sv ***
// sdc_props: port-level properties of sdc_collector
// assumes one clock domain; bound to every sdc_collector instance
`timescale 1ns/100ps
module sdc_props (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // sequencing, data and analog
  input wire logic CONV_START,
  input wire logic CHK_RUN,
  input wire logic CONV_GO,
  input wire logic DATA_VALID,
  input wire logic [23:0] DATA_IN,
  input wire logic BUF_VALID,
  input wire logic [23:0] BUF_DATA,
  input wire logic [13:0] DAC_IN,
  input wire logic [13:0] DAC_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  check_start_a: assert property ($rose(CHK_RUN) |-> $past(CONV_START))
    else $error("check ran without a start");
  go_after_check_a: assert property (CONV_GO |-> $fell(CHK_RUN))
    else $error("go without a finished check");
  buf_code_a: assert property (DATA_VALID |=> BUF_VALID && (BUF_DATA > 24'hfffff7 ||
    BUF_DATA == ($past(DATA_IN) > 24'hfffff7 ? 24'hfffff7 : $past(DATA_IN))))
    else $error("buffered code wrong");
  buf_hold_a: assert property (!BUF_VALID |-> $stable(BUF_DATA))
    else $error("buffered data moved");
  dac_clamp_a: assert property (DAC_OUT == $past(DAC_IN) || DAC_OUT == 14'h3fff ||
    DAC_OUT == 14'h0000)
    else $error("analog code neither input nor clamp");
  apb_ready_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("no ready in access");
  rdata_quiet_a: assert property (!(PSEL && PENABLE && !PWRITE) |-> PRDATA == 32'h0)
    else $error("read data outside a read");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 8'h10 |-> PSLVERR)
    else $error("unmapped access not refused");
endmodule : sdc_props
bind sdc_collector sdc_props u_props (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .PSLVERR, .CONV_START, .CHK_RUN, .CONV_GO, .DATA_VALID, .DATA_IN, .BUF_VALID,
  .BUF_DATA, .DAC_IN, .DAC_OUT);

// *** tb/sdc_seq_model.sv ***
// sdc_seq_model: conversion sequencer and bridge front end facing the collector
// assumes the shared clock; the bench calls convert and checks ok
`timescale 1ns/100ps
module sdc_seq_model (
  // clock and collector answers
  input wire logic CLK,
  input wire logic CHK_RUN,
  input wire logic CONV_GO,
  // strobes to the collector
  output logic CONV_START,
  output logic [1:0] CONV_KIND,
  output logic CONV_END,
  output logic CHK_DONE,
  output logic [15:0] CHK_VEC
);
  initial begin
    CONV_START = 1'b0;
    CONV_KIND = 2'h0;
    CONV_END = 1'b0;
    CHK_DONE = 1'b0;
    CHK_VEC = 16'h0000;
  end
  task automatic convert(input logic [1:0] k, input logic [15:0] v, input int d, output logic ok);
    @(posedge CLK);
    CONV_START <= 1'b1;
    CONV_KIND <= k;
    @(posedge CLK);
    CONV_START <= 1'b0;
    CONV_KIND <= ~k;
    #1;
    ok = CHK_RUN;
    repeat (d + 1) @(posedge CLK);
    CHK_DONE <= 1'b1;
    CHK_VEC <= v;
    @(posedge CLK);
    CHK_DONE <= 1'b0;
    // released vector inverts so a late sample cannot match by luck
    CHK_VEC <= ~v;
    #1;
    ok = ok & CONV_GO & ~CHK_RUN;
    repeat (d + 1) @(posedge CLK);
    CONV_END <= 1'b1;
    @(posedge CLK);
    CONV_END <= 1'b0;
    #1;
  endtask : convert
endmodule : sdc_seq_model

// *** tb/tb.sv ***
// tb: self-checking bench of sdc_collector: apb registers, checks, data and analog paths
// assumes sdc_seq_model as sequencer and the bound sdc_props checker
`timescale 1ns/100ps
module tb;
  logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, e, ok;
  logic CHK_RUN, CONV_GO, CONV_START, CONV_END, CHK_DONE, BUF_VALID, IRQ, DATA_VALID = 0;
  logic [1:0] CONV_KIND;
  logic [7:0] PADDR = 8'h00, st, mk;
  logic [8:0] err = 9'h000, m;
  logic [15:0] CHK_VEC, xchk = 16'h0000;
  logic [23:0] DATA_IN = 24'h0, BUF_DATA, d;
  logic [13:0] DAC_IN = 14'h0, DAC_OUT;
  logic [31:0] PWDATA = 32'h0, PRDATA, q, s = 32'd35798;
  int failures = 0, checked = 0;
  always #5 CLK = ~CLK;
  sdc_seq_model u_seq (.CLK, .CHK_RUN, .CONV_GO, .CONV_START, .CONV_KIND, .CONV_END,
    .CHK_DONE, .CHK_VEC);
  sdc_collector u_dut (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .CONV_START, .CONV_KIND, .CONV_END, .CHK_RUN, .CONV_GO, .CHK_DONE,
    .CHK_VEC, .ADC_OVF(err[0]), .ADC_UDF(err[1]), .CALC_OVF(err[2]), .CALC_UDF(err[3]),
    .THR_HIGH(err[4]), .THR_LOW(err[5]), .BUF_ERR(err[6]), .CRC_COM_ERR(err[7]),
    .CRC_MEM_ERR(err[8]), .DATA_VALID, .DATA_IN, .BUF_VALID, .BUF_DATA, .DAC_IN, .DAC_OUT,
    .IRQ);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  function automatic logic [15:0] gm(input logic [1:0] k);
    return k == 2'h2 ? 16'he000 : k == 2'h1 ? 16'h1c00 : 16'h03ff;
  endfunction : gm
  // sensor, adc and memory pull low; compute and high threshold push full scale
  function automatic logic [13:0] dx(input logic [7:0] t, input logic [13:0] i);
    if (t[0] | t[1] | t[7]) return 14'h0000;
    if (t[2]) return 14'h3fff;
    if (t[4]) return 14'h0000;
    return t[3] ? 14'h3fff : i;
  endfunction : dx
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask : apb
  task automatic conv(input logic [1:0] k, input logic [15:0] v, input logic ow);
    u_seq.convert(k, v, int'(rnd() % 32'd5), ok);
    cmp({31'h0, ok}, 32'h1);
    xchk = ow ? (xchk & ~gm(k)) | (v & gm(k)) : xchk | (v & gm(k));
    apb(1'b0, sdc_pkg::OFS_CHK, 32'h0);
    cmp(q, {16'h0, xchk});
    apb(1'b0, sdc_pkg::OFS_RAW, 32'h0);
    cmp(q, {15'h0, 1'b1, v});
  endtask : conv
  task automatic dat(input logic [23:0] v, input logic [23:0] x);
    @(posedge CLK);
    DATA_VALID <= 1'b1;
    DATA_IN <= v;
    @(posedge CLK);
    DATA_VALID <= 1'b0;
    DATA_IN <= ~v;
    #1;
    cmp({31'h0, BUF_VALID}, 32'h1);
    cmp({8'h0, BUF_DATA}, {8'h0, x});
  endtask : dat
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge CLK);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i <= 20; i += 4) begin
      apb(1'b0, 8'(i), 32'h0);
      cmp(q, 32'h0);
      cmp({31'h0, e}, {31'h0, i == 20});
    end
    $display("test reset values done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, sdc_pkg::OFS_CTRL, 32'(k));
      for (int i = 0; i < 9; i++) begin
        conv(2'(i % 3), i > 5 ? 16'h0 : 16'(rnd()), k[0]);
      end
      $display("test check word mode %0d done", k);
    end
    conv(2'h0, 16'h0001, 1'b1);
    dat(24'(rnd()), 24'hfffff9);
    conv(2'h0, 16'h0000, 1'b1);
    dat(24'hffffff, 24'hfffff7);
    d = 24'(rnd());
    dat(d, d > 24'hfffff7 ? 24'hfffff7 : d);
    @(posedge CLK);
    err <= 9'h008;
    dat(24'h000123, 24'hfffffb);
    @(posedge CLK);
    err <= 9'h001;
    dat(24'h000123, 24'hfffffa);
    @(posedge CLK);
    err <= 9'h000;
    $display("test buffered codes done");
    for (int i = 0; i < 14; i++) begin
      m = i < 9 ? 9'(1 << i) : 9'(rnd());
      mk = 8'(rnd());
      apb(1'b1, sdc_pkg::OFS_CTRL, {30'h0, i != 13, 1'b1});
      apb(1'b1, sdc_pkg::OFS_STAT, 32'hff);
      apb(1'b1, sdc_pkg::OFS_MASK, {24'h0, mk});
      cmp({31'h0, IRQ}, 32'h0);
      if (i > 10) conv(2'h0, 16'h0200, 1'b1);
      @(posedge CLK);
      DAC_IN <= 14'(rnd());
      err <= m;
      @(posedge CLK);
      err <= 9'h000;
      st = {m[8:4], m[3] | m[2], m[1] | m[0], i > 10};
      apb(1'b0, sdc_pkg::OFS_STAT, 32'h0);
      cmp(q, {24'h0, st});
      cmp({31'h0, IRQ}, {31'h0, |(st & mk)});
      cmp({18'h0, DAC_OUT}, {18'h0, i == 13 ? DAC_IN : dx(st, DAC_IN)});
    end
    $display("test status, interrupt and clamp done");
    print_verdict();
  end
endmodule : tb
